// >>> logic/ufb_pkg.sv
/*
 Shared constants and types for the UART flow control, break and status block.
 Assumes one 8-bit register port with word indices and a same-clock receiver front end.
*/
package ufb_pkg;
    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // Register indices
    localparam logic [3:0] REG_DATA = 4'h0;
    localparam logic [3:0] REG_INT_CTRL = 4'h1;
    localparam logic [3:0] REG_EVENT_ID = 4'h2;
    localparam logic [3:0] REG_QUEUE_CTRL = 4'h3;
    localparam logic [3:0] REG_FLOW_CTRL = 4'h4;
    localparam logic [3:0] REG_LINE_FLAGS = 4'h5;
    localparam logic [3:0] REG_HANDSHAKE = 4'h6;
    localparam logic [3:0] REG_RX_LEVEL = 4'h7;
    localparam logic [3:0] REG_TX_LEVEL = 4'h8;
    // Flow control fields
    localparam int FC_AUTO_RTS = 0;
    localparam int FC_AUTO_CTS = 1;
    localparam int FC_POLARITY = 2;
    localparam int FC_LEVEL_LO = 3;
    localparam int FC_LEVEL_HI = 4;
    localparam int FC_MANUAL_RTS = 5;
    localparam int FC_BREAK = 6;
    localparam int FC_FOUR_WIRE = 7;
    localparam logic [7:0] FLOW_CTRL_RESET = 8'h80;
    // Interrupt control fields
    localparam int IC_EN_MODEM = 0;
    localparam int IC_EN_LINE = 1;
    localparam int IC_EN_TX = 2;
    localparam int IC_EN_RXDATA = 3;
    localparam int IC_TRIG_LO = 4;
    localparam int IC_TRIG_HI = 5;
    localparam logic [7:0] INT_CTRL_RESET = 8'h00;
    // Queue control fields
    localparam int QC_TX_FLUSH = 0;
    localparam int QC_RX_FLUSH = 1;
    // Line condition flag positions
    localparam int LS_AVAIL = 0;
    localparam int LS_OVERFLOW = 1;
    localparam int LS_PARITY = 2;
    localparam int LS_FRAMING = 3;
    localparam int LS_BREAK = 4;
    localparam int LS_TXQ_EMPTY = 5;
    localparam int LS_SHIFT_IDLE = 6;
    localparam int LS_ERROR = 7;
    // Handshake flag positions
    localparam int MS_CLEAR_CHANGED = 0;
    localparam int MS_CLEAR_LEVEL = 4;
    // Event identity codes, bits 3:1
    localparam logic [2:0] ID_LINE = 3'h3;
    localparam logic [2:0] ID_RXDATA = 3'h2;
    localparam logic [2:0] ID_TIMEOUT = 3'h6;
    localparam logic [2:0] ID_TX = 3'h1;
    localparam logic [2:0] ID_MODEM = 3'h0;
    // Character timing in bit ticks
    localparam int FRAME_BITS = 10;
    localparam int TIMEOUT_CHARS = 4;
    localparam int TIMEOUT_TICKS = FRAME_BITS * TIMEOUT_CHARS;
    // Character from the receiver front end
    typedef struct packed {
        logic valid;
        logic brk;
        logic framingErr;
        logic parityErr;
        logic [7:0] data;
    } ufb_rxchar_s;
    // Transmit shifter states
    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_SHIFT = 1'b1
    } ufb_txstate_e;
endpackage

// >>> logic/ufb_uart_flow.sv
/*
 UART flow control, break, queue flush and status logic with both character queues and the transmit shifter.
 Assumes a same-clock receiver front end, a one-cycle bit tick from the baud generator, and an asynchronous CTS pin.
*/
// How it works
// - Auto RTS drops at trigger fill level
// - Auto RTS returns once fill falls below
// - Auto CTS gates start of new characters
// - RTS trigger choices 8, 11, 13, 15
// - Polarity bit: low-active clear, high-active set
// - Without auto, software owns RTS, raw CTS
// - Handshake only in four-wire mode
// - Break aborts current character, holds line low
// - Break release resumes sending queued data
// - Separate queue flushes spare current character
// - Flush returns data trigger to one
// - Both queue fill levels readable
// - Line flags read clears error flags only
// - Error summary on parity, framing, break
// - Shifter idle and transmit queue empty flags
// - Break, framing, parity flags from receiver
// - Overflow when character meets full queue
// - Data available while receive queue nonempty
// - CTS level bit 4, change bit 0
// - Identity shows top pending event only
// - Identity codes and priority order
// - Data trigger choices 1, 4, 8, 14
`timescale 1ns/1ps
module ufb_uart_flow #(
    parameter int DEPTH = 16
) (
    // Clock and reset
    input logic clock,
    input logic srst,
    // Register port
    input logic [ufb_pkg::ADDR_W-1:0] regAddr,
    input logic [ufb_pkg::DATA_W-1:0] regWdata,
    input logic regWrite,
    input logic regRead,
    output logic [ufb_pkg::DATA_W-1:0] regRdata,
    // Bit timing and receiver front end
    input logic bitTick,
    input ufb_pkg::ufb_rxchar_s rxChar,
    // Serial pins
    input logic ctsPin,
    output logic txPin,
    output logic rtsPin,
    output logic rtsPinOe
);
    import ufb_pkg::*;

    localparam int PTR_W = $clog2(DEPTH);
    localparam int LVL_W = PTR_W + 1;

    generate
        if (DEPTH < 16 || DEPTH > 128 || (DEPTH & (DEPTH - 1)) != 0) begin : gBadDepth
            $error("DEPTH must be a power of two from 16 to 128");
        end
    endgenerate

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    logic [DATA_W-1:0] rdata_ff;
    logic [7:0] flowCtl_ff;
    logic [7:0] intCtl_ff;
    logic [7:0] txMem [DEPTH];
    logic [7:0] rxMem [DEPTH];
    logic [PTR_W-1:0] txWr_ff;
    logic [PTR_W-1:0] txRd_ff;
    logic [PTR_W-1:0] rxWr_ff;
    logic [PTR_W-1:0] rxRd_ff;
    logic [LVL_W-1:0] txLevel_ff;
    logic [LVL_W-1:0] rxLevel_ff;
    ufb_txstate_e txState_ff;
    logic [9:0] txShift_ff;
    logic [3:0] txBitCnt_ff;
    logic txPin_ff;
    logic rtsPin_ff;
    logic rtsPinOe_ff;
    logic ctsMeta_ff;
    logic ctsSync_ff;
    logic ctsPrev_ff;
    logic clearChanged_ff;
    logic overflow_ff;
    logic parity_ff;
    logic framing_ff;
    logic breakSeen_ff;
    logic errSummary_ff;
    logic [5:0] idleTicks_ff;

    // Register decode
    logic wrData, wrIntCtl, wrQueue, wrFlow, rdData, rdLine, rdHandshake;
    assign wrData = regWrite && regAddr == REG_DATA;
    assign wrIntCtl = regWrite && regAddr == REG_INT_CTRL;
    assign wrQueue = regWrite && regAddr == REG_QUEUE_CTRL;
    assign wrFlow = regWrite && regAddr == REG_FLOW_CTRL;
    assign rdData = regRead && regAddr == REG_DATA;
    assign rdLine = regRead && regAddr == REG_LINE_FLAGS;
    assign rdHandshake = regRead && regAddr == REG_HANDSHAKE;

    // Configuration fields
    logic fourWire, autoRts, autoCts, polarity, breakOn;
    assign fourWire = flowCtl_ff[FC_FOUR_WIRE];
    assign autoRts = flowCtl_ff[FC_AUTO_RTS] && fourWire;
    assign autoCts = flowCtl_ff[FC_AUTO_CTS] && fourWire;
    assign polarity = flowCtl_ff[FC_POLARITY];
    assign breakOn = flowCtl_ff[FC_BREAK];

    function automatic logic [LVL_W-1:0] rtsThreshold(input logic [1:0] sel);
        case (sel)
            2'h0: rtsThreshold = LVL_W'(8);
            2'h1: rtsThreshold = LVL_W'(11);
            2'h2: rtsThreshold = LVL_W'(13);
            default: rtsThreshold = LVL_W'(15);
        endcase
    endfunction

    function automatic logic [LVL_W-1:0] dataThreshold(input logic [1:0] sel);
        case (sel)
            2'h0: dataThreshold = LVL_W'(1);
            2'h1: dataThreshold = LVL_W'(4);
            2'h2: dataThreshold = LVL_W'(8);
            default: dataThreshold = LVL_W'(14);
        endcase
    endfunction

    logic [LVL_W-1:0] rtsThr, dataThr;
    logic rtsWanted, ctsActive, ctsOk;
    assign rtsThr = rtsThreshold(flowCtl_ff[FC_LEVEL_HI:FC_LEVEL_LO]);
    assign dataThr = dataThreshold(intCtl_ff[IC_TRIG_HI:IC_TRIG_LO]);
    assign rtsWanted = rxLevel_ff < rtsThr;
    assign ctsActive = polarity ? ctsSync_ff : !ctsSync_ff;
    assign ctsOk = !autoCts || ctsActive;

    // Queue handshakes
    logic txFull, rxFull, txPush, txLoad, rxPush, rxPop, txFlush, rxFlush;
    assign txFull = txLevel_ff == LVL_W'(DEPTH);
    assign rxFull = rxLevel_ff == LVL_W'(DEPTH);
    assign txFlush = wrQueue && regWdata[QC_TX_FLUSH];
    assign rxFlush = wrQueue && regWdata[QC_RX_FLUSH];
    assign txPush = wrData && !txFull;
    assign txLoad = txState_ff == TX_IDLE && txLevel_ff != '0 && !breakOn && ctsOk;
    assign rxPush = rxChar.valid && !rxFull;
    assign rxPop = rdData && rxLevel_ff != '0;

    // Control registers
    always_ff @(posedge clock) begin
        if (srst) begin
            flowCtl_ff <= FLOW_CTRL_RESET;
        end else if (wrFlow) begin
            flowCtl_ff <= regWdata;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            intCtl_ff <= INT_CTRL_RESET;
        end else if (wrQueue) begin
            intCtl_ff[IC_TRIG_HI:IC_TRIG_LO] <= 2'h0;
        end else if (wrIntCtl) begin
            intCtl_ff <= regWdata;
        end
    end

    // Transmit queue
    always_ff @(posedge clock) begin
        if (txPush) begin
            txMem[txWr_ff] <= regWdata;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            txWr_ff <= '0;
            txRd_ff <= '0;
            txLevel_ff <= '0;
        end else if (txFlush) begin
            txWr_ff <= '0;
            txRd_ff <= '0;
            txLevel_ff <= '0;
        end else begin
            txWr_ff <= txPush ? txWr_ff + PTR_W'(1) : txWr_ff;
            txRd_ff <= txLoad ? txRd_ff + PTR_W'(1) : txRd_ff;
            txLevel_ff <= txLevel_ff + LVL_W'(txPush) - LVL_W'(txLoad);
        end
    end

    // Receive queue
    always_ff @(posedge clock) begin
        if (rxPush) begin
            rxMem[rxWr_ff] <= rxChar.data;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rxWr_ff <= '0;
            rxRd_ff <= '0;
            rxLevel_ff <= '0;
        end else if (rxFlush) begin
            rxWr_ff <= '0;
            rxRd_ff <= '0;
            rxLevel_ff <= '0;
        end else begin
            rxWr_ff <= rxPush ? rxWr_ff + PTR_W'(1) : rxWr_ff;
            rxRd_ff <= rxPop ? rxRd_ff + PTR_W'(1) : rxRd_ff;
            rxLevel_ff <= rxLevel_ff + LVL_W'(rxPush) - LVL_W'(rxPop);
        end
    end

    // Transmit shifter
    always_ff @(posedge clock) begin
        if (srst) begin
            txState_ff <= TX_IDLE;
            txShift_ff <= 10'h3ff;
            txBitCnt_ff <= 4'h0;
        end else begin
            case (txState_ff)
                TX_IDLE: begin
                    if (txLoad) begin
                        txState_ff <= TX_SHIFT;
                        txShift_ff <= {1'b1, txMem[txRd_ff], 1'b0};
                        txBitCnt_ff <= 4'h0;
                    end
                end
                TX_SHIFT: begin
                    if (breakOn) begin
                        txState_ff <= TX_IDLE;
                    end else if (bitTick) begin
                        txShift_ff <= {1'b1, txShift_ff[9:1]};
                        txBitCnt_ff <= txBitCnt_ff + 4'h1;
                        if (txBitCnt_ff == 4'(FRAME_BITS - 1)) begin
                            txState_ff <= TX_IDLE;
                        end
                    end
                end
                default: txState_ff <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            txPin_ff <= 1'b1;
        end else begin
            txPin_ff <= breakOn ? 1'b0 : (txState_ff == TX_SHIFT ? txShift_ff[0] : 1'b1);
        end
    end

    // RTS pin
    always_ff @(posedge clock) begin
        if (srst) begin
            rtsPin_ff <= 1'b0;
            rtsPinOe_ff <= 1'b1;
        end else begin
            rtsPinOe_ff <= fourWire;
            if (!fourWire) begin
                rtsPin_ff <= 1'b1;
            end else if (autoRts) begin
                rtsPin_ff <= polarity ? rtsWanted : !rtsWanted;
            end else begin
                rtsPin_ff <= flowCtl_ff[FC_MANUAL_RTS];
            end
        end
    end

    // CTS synchroniser and change flag
    always_ff @(posedge clock) begin
        if (srst) begin
            ctsMeta_ff <= 1'b0;
            ctsSync_ff <= 1'b0;
            ctsPrev_ff <= 1'b0;
        end else begin
            ctsMeta_ff <= ctsPin;
            ctsSync_ff <= ctsMeta_ff;
            ctsPrev_ff <= ctsSync_ff;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            clearChanged_ff <= 1'b0;
        end else begin
            clearChanged_ff <= (ctsSync_ff != ctsPrev_ff) || (clearChanged_ff && !rdHandshake);
        end
    end

    // Receive error flags, set wins over read clear
    logic setOverflow, setParity, setFraming, setBreak;
    assign setOverflow = rxChar.valid && rxFull;
    assign setParity = rxChar.valid && rxChar.parityErr;
    assign setFraming = rxChar.valid && rxChar.framingErr;
    assign setBreak = rxChar.valid && rxChar.brk;

    always_ff @(posedge clock) begin
        if (srst) begin
            overflow_ff <= 1'b0;
            parity_ff <= 1'b0;
            framing_ff <= 1'b0;
            breakSeen_ff <= 1'b0;
            errSummary_ff <= 1'b0;
        end else begin
            overflow_ff <= setOverflow || (overflow_ff && !rdLine);
            parity_ff <= setParity || (parity_ff && !rdLine);
            framing_ff <= setFraming || (framing_ff && !rdLine);
            breakSeen_ff <= setBreak || (breakSeen_ff && !rdLine);
            errSummary_ff <= setParity || setFraming || setBreak || (errSummary_ff && !rdLine);
        end
    end

    // Receive timeout in bit ticks
    always_ff @(posedge clock) begin
        if (srst) begin
            idleTicks_ff <= '0;
        end else if (rxLevel_ff == '0 || rxPush || rxPop) begin
            idleTicks_ff <= '0;
        end else if (bitTick && idleTicks_ff != 6'(TIMEOUT_TICKS)) begin
            idleTicks_ff <= idleTicks_ff + 6'h1;
        end
    end

    // Status words
    logic [7:0] lineFlags, handshakeFlags, eventId;
    logic lineErr;
    assign lineErr = overflow_ff || parity_ff || framing_ff || breakSeen_ff;
    always_comb begin
        lineFlags = 8'h00;
        lineFlags[LS_AVAIL] = rxLevel_ff != '0;
        lineFlags[LS_OVERFLOW] = overflow_ff;
        lineFlags[LS_PARITY] = parity_ff;
        lineFlags[LS_FRAMING] = framing_ff;
        lineFlags[LS_BREAK] = breakSeen_ff;
        lineFlags[LS_TXQ_EMPTY] = txLevel_ff == '0;
        lineFlags[LS_SHIFT_IDLE] = txState_ff == TX_IDLE;
        lineFlags[LS_ERROR] = errSummary_ff;
        handshakeFlags = 8'h00;
        handshakeFlags[MS_CLEAR_LEVEL] = ctsSync_ff;
        handshakeFlags[MS_CLEAR_CHANGED] = clearChanged_ff;
    end

    always_comb begin
        eventId = 8'h01;
        if (intCtl_ff[IC_EN_LINE] && lineErr) begin
            eventId = {4'h0, ID_LINE, 1'b0};
        end else if (intCtl_ff[IC_EN_RXDATA] && rxLevel_ff >= dataThr) begin
            eventId = {4'h0, ID_RXDATA, 1'b0};
        end else if (intCtl_ff[IC_EN_RXDATA] && idleTicks_ff == 6'(TIMEOUT_TICKS)) begin
            eventId = {4'h0, ID_TIMEOUT, 1'b0};
        end else if (intCtl_ff[IC_EN_TX] && txLevel_ff == '0) begin
            eventId = {4'h0, ID_TX, 1'b0};
        end else if (intCtl_ff[IC_EN_MODEM] && clearChanged_ff) begin
            eventId = {4'h0, ID_MODEM, 1'b0};
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clock) begin
        if (srst || !regRead) begin
            rdata_ff <= 8'h00;
        end else begin
            case (regAddr)
                REG_DATA: rdata_ff <= rxLevel_ff != '0 ? rxMem[rxRd_ff] : 8'h00;
                REG_INT_CTRL: rdata_ff <= intCtl_ff;
                REG_EVENT_ID: rdata_ff <= eventId;
                REG_FLOW_CTRL: rdata_ff <= flowCtl_ff;
                REG_LINE_FLAGS: rdata_ff <= lineFlags;
                REG_HANDSHAKE: rdata_ff <= handshakeFlags;
                REG_RX_LEVEL: rdata_ff <= DATA_W'(rxLevel_ff);
                REG_TX_LEVEL: rdata_ff <= DATA_W'(txLevel_ff);
                default: rdata_ff <= 8'h00;
            endcase
        end
    end

    assign regRdata = rdata_ff;
    assign txPin = txPin_ff;
    assign rtsPin = rtsPin_ff;
    assign rtsPinOe = rtsPinOe_ff;

    // Checks
    AST_RTS_DROP: assert property (autoRts && rxLevel_ff >= rtsThr |=> rtsPin == !$past(polarity))
        else $error("RTS still asserted at trigger level");
    AST_RTS_RETURN: assert property (autoRts && rxLevel_ff < rtsThr |=> rtsPin == $past(polarity))
        else $error("RTS not reasserted below trigger");
    AST_CTS_GATE: assert property (txState_ff == TX_IDLE && autoCts && !ctsActive |=> txState_ff == TX_IDLE)
        else $error("Character started without CTS");
    AST_MANUAL_RTS: assert property (fourWire && !autoRts |=> rtsPin == $past(flowCtl_ff[FC_MANUAL_RTS]))
        else $error("Manual RTS not followed");
    AST_BREAK_HOLD: assert property (breakOn [*2] |-> !txPin && txState_ff == TX_IDLE)
        else $error("Line not held in break");
    AST_BREAK_RESUME: assert property ($fell(breakOn) && txLevel_ff != '0 && ctsOk && txState_ff == TX_IDLE
        |=> txState_ff == TX_SHIFT)
        else $error("Transmit did not resume after break");
    AST_FLUSH_KEEPS: assert property (txFlush && txState_ff == TX_SHIFT && !breakOn && !bitTick
        |=> txLevel_ff == '0 && txState_ff == TX_SHIFT && $stable(txShift_ff))
        else $error("Transmit flush disturbed shifter");
    AST_TRIG_ONE: assert property (wrQueue |=> intCtl_ff[IC_TRIG_HI:IC_TRIG_LO] == 2'h0 && dataThr == LVL_W'(1))
        else $error("Flush left data trigger above one");
    AST_LINE_CLEAR: assert property (rdLine && !rxChar.valid |=> !lineErr && !errSummary_ff
        && regRdata[LS_ERROR] == $past(errSummary_ff))
        else $error("Line flags not cleared by read");
    AST_OVERFLOW: assert property (rxChar.valid && rxFull |=> overflow_ff
        && rxLevel_ff == ($past(rxFlush) ? LVL_W'(0) : $past(rxLevel_ff) - LVL_W'($past(rxPop))))
        else $error("Overflow not flagged");
    AST_AVAIL_READ: assert property (rdLine |=> regRdata[LS_AVAIL] == ($past(rxLevel_ff) != '0))
        else $error("Data available flag wrong");
    AST_CTS_CHANGE: assert property ($changed(ctsSync_ff) |=> clearChanged_ff)
        else $error("CTS change not recorded");
    AST_LINE_FIRST: assert property (regRead && regAddr == REG_EVENT_ID && lineErr && intCtl_ff[IC_EN_LINE]
        |=> regRdata == 8'h06)
        else $error("Line event not reported first");

    COV_BREAK: cover property (txState_ff == TX_SHIFT && breakOn);
    COV_RTS_DROP: cover property (autoRts && rxLevel_ff == rtsThr);
    COV_OVERFLOW: cover property (setOverflow);
    COV_FRAME_DONE: cover property (txState_ff == TX_SHIFT ##1 txState_ff == TX_IDLE);
endmodule

// >>> dv/ufb_remote_peer.sv
/*
 Remote serial peer: hands characters to the receive side, drives CTS, decodes the transmit line.
 Assumes the block's own bit tick and 8N1 frames.
*/
`timescale 1ns/1ps
module ufb_remote_peer (
    // Clock and commands
    input logic clock,
    input logic sendReq,
    input ufb_pkg::ufb_rxchar_s sendChar,
    input logic ctsDrive,
    // Serial side
    input logic bitTick,
    input logic txPin,
    output ufb_pkg::ufb_rxchar_s rxChar,
    output logic ctsPin,
    output logic gotValid,
    output logic [7:0] gotByte
);
    import ufb_pkg::*;
    logic [3:0] bitCnt = 4'h0;
    logic waitIdle = 1'b0;
    logic tickDly = 1'b0;
    assign ctsPin = ctsDrive;
    initial begin
        rxChar = '0;
        gotValid = 1'b0;
        gotByte = 8'h00;
    end
    always @(posedge clock) begin
        rxChar <= sendReq ? sendChar : '0;
        gotValid <= 1'b0;
        // Sample one clock after the tick, just before the pin shows the new bit
        tickDly <= bitTick;
        if (tickDly && waitIdle) begin
            waitIdle <= ~txPin;
        end else if (tickDly && bitCnt == 4'h0) begin
            bitCnt <= txPin ? 4'h0 : 4'h1;
        end else if (tickDly && bitCnt == 4'h9) begin
            // Bad stop bit: drop frame, wait for idle line
            bitCnt <= 4'h0;
            gotValid <= txPin;
            waitIdle <= ~txPin;
        end else if (tickDly) begin
            gotByte <= {txPin, gotByte[7:1]};
            bitCnt <= bitCnt + 4'h1;
        end
    end
endmodule

// >>> dv/testbench.sv
/*
 Self-checking bench for the flow control, break and status block.
 Assumes the peer model and a bit tick every fourth clock.
*/
`timescale 1ns/1ps
module testbench;
    import ufb_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regRdata;
    logic bitTick = 1'b0;
    logic [1:0] tickDiv = 2'h0;
    ufb_rxchar_s rxChar;
    ufb_rxchar_s sendChar = '0;
    logic sendReq = 1'b0;
    logic ctsDrive = 1'b0;
    logic ctsPin, txPin, rtsPin, rtsPinOe, gotValid;
    logic rdSeen = 1'b0;
    logic [7:0] gotByte, b, c;
    logic [7:0] rdQ[$];
    logic [7:0] txQ[$];
    int trig[4] = '{8, 11, 13, 15};
    int bad_count = 0;
    int total_checks = 0;
    int i, lvl;
    ufb_uart_flow ufb_uart_flow_inst (.clock(clock), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .bitTick(bitTick), .rxChar(rxChar),
        .ctsPin(ctsPin), .txPin(txPin), .rtsPin(rtsPin), .rtsPinOe(rtsPinOe));
    ufb_remote_peer ufb_remote_peer_inst (.clock(clock), .sendReq(sendReq), .sendChar(sendChar),
        .ctsDrive(ctsDrive), .bitTick(bitTick), .txPin(txPin), .rxChar(rxChar), .ctsPin(ctsPin),
        .gotValid(gotValid), .gotByte(gotByte));
    initial begin
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        tickDiv <= tickDiv + 2'h1;
        bitTick <= (tickDiv == 2'h3);
        rdSeen <= regRead;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Results are compared against the oldest note
    always @(negedge clock) begin
        if (rdSeen) begin
            check(regRdata, rdQ.pop_front());
        end
        if (gotValid) begin
            check(gotByte, txQ.size() > 0 ? txQ.pop_front() : 8'hxx);
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        rdQ.push_back(e);
        @(posedge clock);
        regRead <= 1'b0;
    endtask
    task automatic send(input logic [2:0] f, input logic [7:0] d);
        @(posedge clock);
        sendReq <= 1'b1;
        sendChar <= {1'b1, f, d};
        @(posedge clock);
        sendReq <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
    task automatic pin(input int sel, input logic e);
        repeat (3) @(posedge clock);
        @(negedge clock);
        check({7'h0, sel == 0 ? rtsPin : sel == 1 ? rtsPinOe : txPin}, {7'h0, e});
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(88324));
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        pin(1, 1'b1);
        pin(2, 1'b1);
        rd(REG_FLOW_CTRL, FLOW_CTRL_RESET);
        rd(REG_LINE_FLAGS, 8'h60);
        rd(REG_EVENT_ID, 8'h01);
        rd(REG_HANDSHAKE, 8'h00);
        for (lvl = 0; lvl < 4; lvl++) begin
            wr(REG_QUEUE_CTRL, 8'h02);
            wr(REG_FLOW_CTRL, 8'h81 | 8'(lvl << 3) | 8'((lvl & 1) << 2));
            b = 8'($urandom);
            send(3'h0, b);
            for (i = 2; i < trig[lvl]; i++) begin
                send(3'h0, 8'($urandom));
            end
            pin(0, lvl[0]);
            send(3'h0, 8'($urandom));
            pin(0, ~lvl[0]);
            rd(REG_RX_LEVEL, 8'(trig[lvl]));
            rd(REG_DATA, b);
            pin(0, lvl[0]);
        end
        for (i = 0; i < 3; i++) begin
            send(3'h0, 8'($urandom));
        end
        rd(REG_LINE_FLAGS, 8'h63);
        rd(REG_LINE_FLAGS, 8'h61);
        wr(REG_INT_CTRL, 8'h3f);
        for (i = 0; i < 3; i++) begin
            wr(REG_QUEUE_CTRL, 8'h02);
            send(3'h0, 8'($urandom));
            send(3'(1 << i), 8'($urandom));
            rd(REG_EVENT_ID, 8'h06);
            rd(REG_LINE_FLAGS, 8'he1 | (8'h04 << i));
            rd(REG_EVENT_ID, 8'h04);
        end
        wr(REG_INT_CTRL, 8'h1f);
        repeat (170) @(posedge clock);
        rd(REG_EVENT_ID, 8'h0c);
        wr(REG_QUEUE_CTRL, 8'h02);
        rd(REG_EVENT_ID, 8'h02);
        wr(REG_FLOW_CTRL, 8'ha4);
        pin(0, 1'b1);
        wr(REG_FLOW_CTRL, 8'h84);
        pin(0, 1'b0);
        wr(REG_FLOW_CTRL, 8'h00);
        pin(1, 1'b0);
        wr(REG_INT_CTRL, 8'h01);
        ctsDrive <= 1'b1;
        repeat (6) @(posedge clock);
        rd(REG_EVENT_ID, 8'h00);
        rd(REG_HANDSHAKE, 8'h11);
        rd(REG_HANDSHAKE, 8'h10);
        rd(REG_EVENT_ID, 8'h01);
        wr(REG_FLOW_CTRL, 8'h86);
        b = 8'($urandom);
        c = 8'($urandom);
        wr(REG_DATA, b);
        wr(REG_DATA, c);
        repeat (8) @(posedge clock);
        wr(REG_FLOW_CTRL, 8'hc6);
        ctsDrive <= 1'b0;
        pin(2, 1'b0);
        repeat (60) @(posedge clock);
        rd(REG_TX_LEVEL, 8'h01);
        wr(REG_FLOW_CTRL, 8'h86);
        pin(2, 1'b1);
        repeat (40) @(posedge clock);
        rd(REG_LINE_FLAGS, 8'h40);
        txQ.push_back(c);
        ctsDrive <= 1'b1;
        repeat (80) @(posedge clock);
        rd(REG_LINE_FLAGS, 8'h60);
        b = 8'($urandom);
        txQ.push_back(b);
        wr(REG_DATA, b);
        wr(REG_DATA, 8'($urandom));
        repeat (8) @(posedge clock);
        wr(REG_QUEUE_CTRL, 8'h01);
        rd(REG_TX_LEVEL, 8'h00);
        repeat (80) @(posedge clock);
        check(8'(txQ.size()), 8'h00);
        tally_and_finish();
    end
endmodule
